// file: verilog/cell_discharge_pkg.sv
`default_nettype none
package cell_discharge_pkg;

  // Geometry of the balancing block
  localparam int CHANNELS   = 16;
  localparam int DUTY_W     = 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int FLAGS_W    = 32;
  localparam int TOUT_W     = 6;
  localparam int CLEAR_BYTES = 6;

  // Register byte addresses on the APB slave
  localparam logic [ADDR_W-1:0] DUTY_LO_ADDR  = 8'h00;
  localparam logic [ADDR_W-1:0] DUTY_HI_ADDR  = 8'h04;
  localparam logic [ADDR_W-1:0] CONFIG_B_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] COMMAND_ADDR  = 8'h0C;
  localparam logic [ADDR_W-1:0] CLEAR_LO_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] CLEAR_HI_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_D_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] CONFIG_A_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] PINS_ADDR     = 8'h20;

  // Configuration group B field layout
  localparam int CFGB_STATIC_LSB = 0;
  localparam int CFGB_TOUT_LSB   = 16;

  // Command register bit positions
  localparam int CMD_MUTE      = 0;
  localparam int CMD_UNMUTE    = 1;
  localparam int CMD_CELL_CONV = 2;
  localparam int CMD_RED_CONV  = 3;
  localparam int CMD_PERMIT    = 4;
  localparam int CMD_FREE_RUN  = 5;
  localparam int CMD_WIRE_LSB  = 6;

  // Configuration group A read-only bit positions
  localparam int CFGA_MUTE     = 0;
  localparam int CFGA_EXT_BAL  = 1;
  localparam int CFGA_ADC_MUTE = 2;
  localparam int CFGA_BUSY     = 3;
  localparam int CFGA_RESULTS  = 4;
  localparam int CFGA_THSD     = 5;
  localparam int CFGA_WIRE_LSB = 6;

  // Reset values
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [TOUT_W-1:0] TOUT_NONE = 6'h00;

  // Timing at the 200 MHz clock
  localparam int CLK_KHZ           = 200_000;
  localparam int PWM_PERIOD_MS     = 937;
  localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_MS * CLK_KHZ;
  localparam int DUTY_STEPS        = 15;
  localparam int PWM_SLOT_CYCLES   = PWM_PERIOD_CYCLES / DUTY_STEPS;
  localparam int SYNC_MS           = 8;
  localparam int SYNC_CYCLES       = SYNC_MS * CLK_KHZ;
  localparam int CONV_MS           = 8;
  localparam int CONV_CYCLES       = CONV_MS * CLK_KHZ;
  localparam logic [DUTY_W-1:0] LAST_SLOT = 4'(DUTY_STEPS - 1);

  // Conversion sequencer for cell and redundant commands, Gray coded
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SYNC = 2'b01,
    CONV_RUN  = 2'b11
  } conv_state_t;

endpackage
`default_nettype wire

// file: verilog/cell_discharge_arbiter.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cell_discharge_arbiter
  import cell_discharge_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = cell_discharge_pkg::PWM_SLOT_CYCLES,
  parameter int unsigned SYNC_TIME   = cell_discharge_pkg::SYNC_CYCLES,
  parameter int unsigned CONV_TIME   = cell_discharge_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst,
  // APB slave
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [cell_discharge_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [cell_discharge_pkg::DATA_W-1:0]    pwdata,
  output var  logic [cell_discharge_pkg::DATA_W-1:0]    prdata,
  output var  logic                                     pready,
  output var  logic                                     pslverr,
  // Device state from surrounding logic
  input  wire logic                                     active_state,
  input  wire logic                                     low_power_monitoring_mode,
  input  wire logic                                     thermal_shutdown,
  input  wire logic                                     watchdog_expired,
  input  wire logic                                     sleep_entry,
  input  wire logic [cell_discharge_pkg::FLAGS_W-1:0]   voltage_flag_set,
  // Balancing outputs
  output var  logic [cell_discharge_pkg::CHANNELS-1:0]  balance_pin,
  output var  logic                                     mute_active,
  output var  logic                                     results_ready
);
  import cell_discharge_pkg::*;

  // Behaviour notes
  // Every source is re-arbitrated each cycle, so a pin follows
  // its cause with one cycle of register delay.
  // Thermal shutdown is a level: while it stands, duty and static
  // settings are wiped every cycle and all pins stay low.
  // Mute is a state bit outside group B so that group B reads
  // and writes never disturb it.
  // A group B write blanks all pins, a duty write all pins not in
  // static discharge, for the whole transfer, setup cycle included,
  // trading a short gap for no glitch on a half-written setting.
  // The conversion suppression is set by a start command without
  // permit outside extended balancing and low power monitoring, and
  // cleared by a permitted command or by the end of a single-shot run.
  // Free-running conversions keep the suppression until a new
  // command arrives; software must send a permitted single shot.
  // The synchronisation wait is always the worst case, so results
  // never come early but may come later than strictly needed.
  // A watchdog pulse with a live timeout clears static discharge
  // and keeps only PWM going; with no timeout it acts as sleep.
  // The PWM time base is free running and shared by all pins,
  // so channels with equal duty switch together.
  // Voltage flags are sticky; a set pulse beats a clear that
  // lands in the same cycle.

  typedef struct packed {
    // Registered APB answer
    logic [DATA_W-1:0]            prdata;
    // One-cycle ready pulse
    logic                         pready;
    // Error for unmapped addresses
    logic                         pslverr;
    // Four duty bits per channel
    logic [CHANNELS*DUTY_W-1:0]   duty;
    // Static discharge requests
    logic [CHANNELS-1:0]          static_discharge_bits;
    // Discharge timeout, zero means none
    logic [TOUT_W-1:0]            discharge_timeout_field;
    // Mute state, kept out of group B
    logic                         mute;
    // Extended balancing after watchdog
    logic                         ext_bal;
    // First four clear mask bytes
    logic [DATA_W-1:0]            clear_lo;
    // Sticky voltage flags
    logic [FLAGS_W-1:0]           status_group_d;
    // Conversion sequencer state
    conv_state_t                  conv;
    // Sequencer cycle count
    logic [31:0]                  conv_cnt;
    // Conversion repeats until told otherwise
    logic                         free_running_flag;
    // Open-wire selection of the last command
    logic [1:0]                   open_wire_select;
    // PWM suppressed by a conversion
    logic                         adc_mute;
    // Conversion results available
    logic                         results;
    // Cycles within the current PWM slot
    logic [31:0]                  slot_cnt;
    // Current PWM slot
    logic [DUTY_W-1:0]            slot;
    // Registered pin drive
    logic [CHANNELS-1:0]          pins;
  } state_t;

  state_t st;
  state_t next_st;

  logic                         setup;
  logic                         wr;
  logic                         mapped;
  logic                         cfgb_write;
  logic                         duty_write;
  logic                         pwm_ok;
  logic                         static_ok;
  logic                         to_sleep;
  logic                         start_cmd;
  logic                         permit;
  logic [FLAGS_W-1:0]           clear_mask;
  logic [DATA_W-1:0]            rd_word;
  logic [DATA_W-1:0]            cfga_word;
  logic [DUTY_W-1:0]            duty_ch;

  // Address decode and the combined next-state
  always_comb begin
    next_st    = st;
    setup      = psel && !penable;
    mapped     = (paddr == DUTY_LO_ADDR) || (paddr == DUTY_HI_ADDR) ||
                 (paddr == CONFIG_B_ADDR) || (paddr == COMMAND_ADDR) ||
                 (paddr == CLEAR_LO_ADDR) || (paddr == CLEAR_HI_ADDR) ||
                 (paddr == STATUS_D_ADDR) || (paddr == CONFIG_A_ADDR) ||
                 (paddr == PINS_ADDR);
    wr         = psel && penable && pwrite && st.pready && !st.pslverr;
    // Whole transfer counts as the write window, setup cycle included
    cfgb_write = psel && pwrite && (paddr == CONFIG_B_ADDR);
    duty_write = psel && pwrite && ((paddr == DUTY_LO_ADDR) || (paddr == DUTY_HI_ADDR));
    to_sleep   = sleep_entry || (watchdog_expired && (st.discharge_timeout_field == TOUT_NONE));
    start_cmd  = wr && (paddr == COMMAND_ADDR) &&
                 (pwdata[CMD_CELL_CONV] || pwdata[CMD_RED_CONV]);
    permit     = pwdata[CMD_PERMIT];
    clear_mask = ZERO_WORD;
    duty_ch    = '0;

    // Read-only view of configuration group A
    cfga_word                          = ZERO_WORD;
    cfga_word[CFGA_MUTE]               = st.mute;
    cfga_word[CFGA_EXT_BAL]            = st.ext_bal;
    cfga_word[CFGA_ADC_MUTE]           = st.adc_mute;
    cfga_word[CFGA_BUSY]               = (st.conv != CONV_IDLE);
    cfga_word[CFGA_RESULTS]            = st.results;
    cfga_word[CFGA_THSD]               = thermal_shutdown;
    cfga_word[CFGA_WIRE_LSB +: 2]      = st.open_wire_select;

    // Read mux, sampled in the setup cycle
    case (paddr)
      DUTY_LO_ADDR:  rd_word = st.duty[DATA_W-1:0];
      DUTY_HI_ADDR:  rd_word = st.duty[2*DATA_W-1:DATA_W];
      CONFIG_B_ADDR: begin
        rd_word = ZERO_WORD;
        rd_word[CFGB_STATIC_LSB +: CHANNELS] = st.static_discharge_bits;
        rd_word[CFGB_TOUT_LSB +: TOUT_W]     = st.discharge_timeout_field;
      end
      CLEAR_LO_ADDR: rd_word = st.clear_lo;
      STATUS_D_ADDR: rd_word = st.status_group_d;
      CONFIG_A_ADDR: rd_word = cfga_word;
      PINS_ADDR: begin
        rd_word = ZERO_WORD;
        rd_word[CHANNELS-1:0] = st.pins;
      end
      default:       rd_word = ZERO_WORD;
    endcase

    // APB answer: one wait-free access phase, registered outputs
    next_st.pready  = setup;
    next_st.pslverr = setup && !mapped;
    next_st.prdata  = (setup && !pwrite && mapped) ? rd_word : ZERO_WORD;

    // Register writes, taken at the completing access edge
    if (wr) begin
      // Any valid command ends extended balancing
      next_st.ext_bal = 1'b0;
      case (paddr)
        DUTY_LO_ADDR:  next_st.duty[DATA_W-1:0] = pwdata;
        DUTY_HI_ADDR:  next_st.duty[2*DATA_W-1:DATA_W] = pwdata;
        CONFIG_B_ADDR: begin
          // Mute bit lives elsewhere so group B writes leave it alone
          next_st.static_discharge_bits   = pwdata[CFGB_STATIC_LSB +: CHANNELS];
          next_st.discharge_timeout_field = pwdata[CFGB_TOUT_LSB +: TOUT_W];
        end
        COMMAND_ADDR: begin
          if (pwdata[CMD_MUTE]) begin
            next_st.mute = 1'b1;
          end else if (pwdata[CMD_UNMUTE]) begin
            next_st.mute = 1'b0;
          end
        end
        CLEAR_LO_ADDR: next_st.clear_lo = pwdata;
        CLEAR_HI_ADDR: begin
          // Last two mask bytes complete the six-byte clear; they map nowhere
          clear_mask = st.clear_lo;
        end
        default: begin
        end
      endcase
    end

    // Voltage flags: set wins over a clear in the same cycle
    next_st.status_group_d = (st.status_group_d & ~clear_mask) | voltage_flag_set;

    // Conversion sequencer for cell and redundant commands
    case (st.conv)
      CONV_IDLE: begin
        next_st.conv_cnt = '0;
      end
      CONV_SYNC: begin
        if (st.conv_cnt >= SYNC_TIME - 1) begin
          next_st.conv_cnt = '0;
          next_st.conv     = CONV_RUN;
        end else begin
          next_st.conv_cnt = st.conv_cnt + 32'h0000_0001;
        end
      end
      CONV_RUN: begin
        if (st.conv_cnt >= CONV_TIME - 1) begin
          next_st.conv_cnt = '0;
          next_st.results  = 1'b1;
          if (!st.free_running_flag) begin
            // Single shot done: release the suspension
            next_st.conv     = CONV_IDLE;
            next_st.adc_mute = 1'b0;
          end
        end else begin
          next_st.conv_cnt = st.conv_cnt + 32'h0000_0001;
        end
      end
      default: begin
        next_st.conv     = CONV_IDLE;
        next_st.conv_cnt = '0;
      end
    endcase

    // A new command restarts the sequencer; it sets the suspension only without permit, ext_bal or low power monitoring
    if (start_cmd) begin
      next_st.free_running_flag = pwdata[CMD_FREE_RUN];
      next_st.open_wire_select  = pwdata[CMD_WIRE_LSB +: 2];
      next_st.results           = 1'b0;
      next_st.conv_cnt          = '0;
      // Permitted command restarts discharge at once
      next_st.adc_mute = !permit && !st.ext_bal && !low_power_monitoring_mode;
      if (pwdata[CMD_RED_CONV] && (st.conv == CONV_IDLE)) begin
        next_st.conv = CONV_SYNC;
      end else begin
        // Already synchronised or cell run: one further conversion
        next_st.conv = CONV_RUN;
      end
    end

    // PWM time base: 15 slots make one period
    if (st.slot_cnt >= SLOT_CYCLES - 1) begin
      next_st.slot_cnt = '0;
      next_st.slot     = (st.slot == LAST_SLOT) ? '0 : st.slot + 4'h1;
    end else begin
      next_st.slot_cnt = st.slot_cnt + 32'h0000_0001;
    end

    // Watchdog with a live timeout: keep only PWM going
    if (watchdog_expired && !to_sleep) begin
      next_st.static_discharge_bits = '0;
      next_st.mute                  = 1'b0;
      next_st.ext_bal               = 1'b1;
    end

    // Sleep resets settings, sequencer and sticky flags; open-wire select and free-run flag keep their values
    if (to_sleep) begin
      next_st.duty                    = '0;
      next_st.static_discharge_bits   = '0;
      next_st.discharge_timeout_field = TOUT_NONE;
      next_st.mute                    = 1'b0;
      next_st.ext_bal                 = 1'b0;
      next_st.clear_lo                = ZERO_WORD;
      next_st.status_group_d          = '0;
      next_st.conv                    = CONV_IDLE;
      next_st.adc_mute                = 1'b0;
      next_st.results                 = 1'b0;
    end

    // Thermal shutdown clears PWM and static settings
    if (thermal_shutdown) begin
      next_st.duty                  = '0;
      next_st.static_discharge_bits = '0;
    end

    // Qualifiers for the lower sources
    pwm_ok    = (active_state || st.ext_bal) &&
                (st.discharge_timeout_field != TOUT_NONE);
    // Static discharge is off in extended balancing; the watchdog has cleared its bits
    static_ok = !st.ext_bal;

    // Seven-level arbitration, one pin at a time, every cycle
    for (int i = 0; i < CHANNELS; i++) begin
      duty_ch = st.duty[i*DUTY_W +: DUTY_W];
      if (thermal_shutdown) begin
        next_st.pins[i] = 1'b0;
      end else if (st.mute || (wr && (paddr == COMMAND_ADDR) && pwdata[CMD_MUTE])) begin
        // Switches drop together with mute_active, at the edge that takes the command
        next_st.pins[i] = 1'b0;
      end else if (cfgb_write) begin
        next_st.pins[i] = 1'b0;
      end else if (st.static_discharge_bits[i] && static_ok) begin
        next_st.pins[i] = 1'b1;
      end else if (st.adc_mute) begin
        next_st.pins[i] = 1'b0;
      end else if (duty_write) begin
        next_st.pins[i] = 1'b0;
      end else begin
        // Duty 15 keeps slot below it for the whole period
        next_st.pins[i] = pwm_ok && (st.slot < duty_ch);
      end
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign balance_pin   = st.pins;
  assign mute_active   = st.mute;
  assign results_ready = st.results;

endmodule
`default_nettype wire

// file: tb/discharge_props.sv
`timescale 1ns/1ps
`default_nettype none
module discharge_props
  import cell_discharge_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = 4,
  parameter int unsigned SYNC_TIME   = 5,
  parameter int unsigned CONV_TIME   = 9
) (
  // Clock and reset
  input wire logic                                    clk,
  input wire logic                                    rst,
  // APB request
  input wire logic                                    psel,
  input wire logic                                    penable,
  input wire logic                                    pwrite,
  input wire logic [cell_discharge_pkg::ADDR_W-1:0]   paddr,
  input wire logic [cell_discharge_pkg::DATA_W-1:0]   pwdata,
  input wire logic                                    pready,
  // Device state and outputs
  input wire logic                                    thermal_shutdown,
  input wire logic                                    watchdog_expired,
  input wire logic                                    sleep_entry,
  input wire logic [cell_discharge_pkg::CHANNELS-1:0] balance_pin,
  input wire logic                                    mute_active,
  input wire logic                                    results_ready
);
  // Worst redundant run plus margin for the command edge
  localparam int RES_MAX = int'(SYNC_TIME + CONV_TIME) + 3;
  logic cmd_wr;

  // Accepted write to the command register
  assign cmd_wr = psel && penable && pready && pwrite && paddr == COMMAND_ADDR;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_THERMAL_GATE: assert property (
    thermal_shutdown |=> balance_pin == '0) else $error("pins on in thermal shutdown");
  AST_MUTE_GATE: assert property (
    mute_active |=> balance_pin == '0) else $error("pins on while muted");
  AST_MUTE_CMD: assert property (
    cmd_wr && pwdata[CMD_MUTE] |=> mute_active ##1 balance_pin == '0)
    else $error("mute command slow");
  AST_UNMUTE_CMD: assert property (
    cmd_wr && pwdata[CMD_UNMUTE] && !pwdata[CMD_MUTE] |=> !mute_active)
    else $error("unmute ignored");
  AST_MUTE_HOLD: assert property (
    mute_active && !watchdog_expired && !sleep_entry && !(cmd_wr && pwdata[CMD_UNMUTE])
    |=> mute_active) else $error("mute dropped");
  AST_WD_UNMUTE: assert property (
    watchdog_expired |=> !mute_active) else $error("watchdog kept mute");
  AST_CFGB_WINDOW: assert property (
    psel && pwrite && paddr == CONFIG_B_ADDR |=> balance_pin == '0)
    else $error("pins on during group B write");
  AST_SLEEP_CLEAR: assert property (
    sleep_entry |=> !mute_active ##1 balance_pin == '0) else $error("sleep left state");
  AST_RESULTS: assert property (
    cmd_wr && (pwdata[CMD_RED_CONV] || pwdata[CMD_CELL_CONV])
    |=> !results_ready ##[1:RES_MAX] results_ready) else $error("results late");

  // Main scenarios reached
  cover property (cmd_wr && pwdata[CMD_MUTE]);
  cover property ($rose(results_ready));
  cover property (thermal_shutdown);
endmodule

bind cell_discharge_arbiter discharge_props #(
  .SLOT_CYCLES(SLOT_CYCLES), .SYNC_TIME(SYNC_TIME), .CONV_TIME(CONV_TIME)
) u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .thermal_shutdown(thermal_shutdown),
  .watchdog_expired(watchdog_expired), .sleep_entry(sleep_entry),
  .balance_pin(balance_pin), .mute_active(mute_active), .results_ready(results_ready));
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cell_discharge_pkg::*;
(
  // Clock
  input  wire logic                                  clk,
  // APB master
  output var  logic                                  psel,
  output var  logic                                  penable,
  output var  logic                                  pwrite,
  output var  logic [cell_discharge_pkg::ADDR_W-1:0] paddr,
  output var  logic [cell_discharge_pkg::DATA_W-1:0] pwdata,
  input  wire logic [cell_discharge_pkg::DATA_W-1:0] prdata,
  input  wire logic                                  pready,
  input  wire logic                                  pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // One transfer; released lines show inverted data so stale values never match
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1) tb_top.hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q, output logic e);
    xfer(1'b0, a, '0, q, e);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cell_discharge_pkg::*;
  // Bench signals
  logic                clk;
  logic                rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic                act;
  logic                lpm;
  logic                hot;
  logic                wd;
  logic                slp;
  logic [FLAGS_W-1:0]  vset;
  logic [CHANNELS-1:0] pins;
  logic                mute;
  logic                res;
  logic [DATA_W-1:0]   q;
  logic                e;
  int                  n_mismatch;
  int                  checked;

  // Short counts keep a PWM period at 60 cycles
  cell_discharge_arbiter #(.SLOT_CYCLES(4), .SYNC_TIME(5), .CONV_TIME(9)) DUT (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_state(act), .low_power_monitoring_mode(lpm), .thermal_shutdown(hot),
    .watchdog_expired(wd), .sleep_entry(slp), .voltage_flag_set(vset),
    .balance_pin(pins), .mute_active(mute), .results_ready(res));
  host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    $display("unexpected at %0t: handshake timeout", $time);
    end_of_test();
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host.rd(a, q, e);
    chk(q, exp);
  endtask

  // On-cycles of one pin over a full PWM period
  task automatic on_chk(input int p, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] c;
    c = '0;
    repeat (60) begin
      @(posedge clk);
      c = c + pins[p];
    end
    chk(c, exp);
  endtask

  // Conversion: pin 0 state while running and after results
  task automatic conv(input logic [DATA_W-1:0] cmd, input logic dur, input logic aft);
    logic seen;
    int   n;
    seen = 1'b0;
    n = 0;
    host.wr(COMMAND_ADDR, cmd);
    repeat (2) @(posedge clk);
    while (res !== 1'b1 && n < 40) begin
      seen = seen | pins[0];
      @(posedge clk);
      n++;
    end
    if (res !== 1'b1) hang();
    chk({31'h0000_0000, res}, 32'h0000_0001);
    chk({31'h0000_0000, seen}, {31'h0000_0000, dur});
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, pins[0]}, {31'h0000_0000, aft});
  endtask

  task automatic t_pwm();
    host.rd(8'hFC, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    rd_chk(CONFIG_A_ADDR, ZERO_WORD);
    host.wr(CONFIG_B_ADDR, 32'h0001_0008);
    host.wr(DUTY_LO_ADDR, 32'h0000_050F);
    repeat (2) @(posedge clk);
    on_chk(0, 32'h0000_003C);
    on_chk(2, 32'h0000_0014);
    on_chk(1, 32'h0000_0000);
    on_chk(3, 32'h0000_003C);
    act <= 1'b0;
    repeat (2) @(posedge clk);
    chk({16'h0000, pins & 16'h0005}, ZERO_WORD);
    act <= 1'b1;
    host.wr(CONFIG_B_ADDR, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk({16'h0000, pins}, 32'h0000_0008);
    host.wr(CONFIG_B_ADDR, 32'h0001_0008);
  endtask

  task automatic t_conv();
    conv(32'h0000_0008, 1'b0, 1'b1);
    conv(32'h0000_0004, 1'b0, 1'b1);
    conv(32'h0000_0028, 1'b0, 1'b0);
    conv(32'h0000_0018, 1'b1, 1'b1);
    conv(32'h0000_0048, 1'b0, 1'b1);
    conv(32'h0000_0088, 1'b0, 1'b1);
    lpm <= 1'b1;
    conv(32'h0000_0008, 1'b1, 1'b1);
    lpm <= 1'b0;
  endtask

  task automatic t_mute();
    host.wr(COMMAND_ADDR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({16'h0000, pins}, ZERO_WORD);
    host.rd(CONFIG_A_ADDR, q, e);
    chk(q & 32'h0000_0001, 32'h0000_0001);
    chk({31'h0000_0000, mute}, 32'h0000_0001);
    rd_chk(CONFIG_B_ADDR, 32'h0001_0008);
    host.wr(COMMAND_ADDR, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk({16'h0000, pins & 16'h0009}, 32'h0000_0009);
    host.wr(COMMAND_ADDR, 32'h0000_0001);
    @(posedge clk);
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    host.rd(CONFIG_A_ADDR, q, e);
    chk(q & 32'h0000_0003, 32'h0000_0002);
    rd_chk(CONFIG_B_ADDR, 32'h0001_0000);
    chk({16'h0000, pins & 16'h0009}, 32'h0000_0001);
  endtask

  task automatic t_flags();
    @(posedge clk);
    vset <= 32'h0000_0023;
    @(posedge clk);
    vset <= '0;
    rd_chk(STATUS_D_ADDR, 32'h0000_0023);
    host.wr(CLEAR_LO_ADDR, 32'h0000_0021);
    rd_chk(STATUS_D_ADDR, 32'h0000_0023);
    host.wr(CLEAR_HI_ADDR, ZERO_WORD);
    rd_chk(STATUS_D_ADDR, 32'h0000_0002);
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    rd_chk(STATUS_D_ADDR, ZERO_WORD);
  endtask

  task automatic t_thermal();
    host.wr(CONFIG_B_ADDR, 32'h0001_0002);
    host.wr(DUTY_LO_ADDR, 32'h0000_000F);
    hot <= 1'b1;
    repeat (2) @(posedge clk);
    chk({16'h0000, pins}, ZERO_WORD);
    hot <= 1'b0;
    rd_chk(DUTY_LO_ADDR, ZERO_WORD);
    rd_chk(CONFIG_B_ADDR, 32'h0001_0000);
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    checked = 0;
    rst = 1'b1;
    act = 1'b1;
    lpm = 1'b0;
    hot = 1'b0;
    wd = 1'b0;
    slp = 1'b0;
    vset = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_pwm();
    t_conv();
    t_mute();
    t_flags();
    t_thermal();
    end_of_test();
  end
endmodule
`default_nettype wire
